/* File: design/sade_alarm.sv */
// servo alarm detection, first-alarm latch and three-line alarm code encoder
// Operation
// - feedback option timer failure gives group-one, no-reset alarm, code low high low.
// - deviation above overflow level while servo on and not speed-limited gives group-one resettable alarm.
// - servo turned on after off-state deviation exceeded servo-on level: group-one resettable.
// - servo-on with remaining deviation limits speed to servo-on limit until cleared.
// - pulses during speed limit and deviation over level: group-two resettable alarm.
// - excessive motor-load deviation in fully-closed loop gives group-two resettable alarm.
// - position feedback outside signed permitted range gives group-one no-reset alarm.
// - option module detection failure or unsupported safety module: group-one no-reset alarm.
// - safety input timing error gives group-one no-reset alarm, code high low low.
// - either gate drive fault gives group-one no-reset alarm, code high low low.
`timescale 1ns/1ps
`default_nettype none
module sade_alarm
  import sade_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // servo state and position data (same clock domain)
  input wire logic servoOn,
  input wire logic fullyClosed,
  input wire logic refPulse,
  input wire logic [DEV_W-1:0] posDeviation,
  input wire logic [DEV_W-1:0] loadDeviation,
  input wire logic [POS_W-1:0] posFeedback,
  // settings
  input wire logic [LVL_W-1:0] deviation_overflow_level,
  input wire logic [LVL_W-1:0] servo_on_overflow_level,
  input wire logic [LVL_W-1:0] loadDeviationLevel,
  input wire logic [SPD_W-1:0] servo_on_speed_limit_rot,
  input wire logic [SPD_W-1:0] servo_on_speed_limit_lin,
  input wire logic linearMotor,
  input wire logic speedLimitClear,
  // fault inputs from pins (asynchronous)
  input wire logic fbTimerFault,
  input wire logic safetyDetectFail,
  input wire logic feedbackDetectFail,
  input wire logic safetyUnsupported,
  input wire logic safetyTimingFault,
  input wire logic gateFaultOne,
  input wire logic gateFaultTwo,
  // alarm reset request (same clock domain, pulse or level)
  input wire logic alarmReset,
  // alarm outputs
  output logic alarm_code_line_one,
  output logic alarm_code_line_two,
  output logic alarm_code_line_three,
  output logic alarmActive,
  output logic stop_group_one,
  output logic stop_group_two,
  output logic alarmResettable,
  output logic [SRC_W-1:0] alarmSource,
  output logic speedLimitActive,
  output logic [SPD_W-1:0] speedLimitValue
);
  localparam int NUM_PIN = 7;
  logic [NUM_PIN-1:0] pinRaw;
  logic [NUM_PIN-1:0] pinSync;
  logic [DEV_W-1:0] devMag;
  logic [DEV_W-1:0] loadMag;
  logic [POS_W-1:0] posMag;
  logic devOver;
  logic devAtOnOver;
  logic loadOver;
  logic posOver;
  logic servoOnPrev_r;
  logic servoOnRise;
  logic offOverflow_r;
  logic limit_r;
  logic limitPulse_r;
  logic [NUM_SRC:0] detect;
  sade_state_t state_r;
  logic [SRC_W-1:0] src_r;
  logic [SRC_W-1:0] src_nxt;
  logic [2:0] code_r;
  logic [2:0] code_nxt;
  sade_grp_t grp_r;
  sade_grp_t grp_nxt;
  logic canReset_r;
  logic canReset_nxt;
  logic anyDetect;

  // gather the pin-level fault inputs in a fixed order
  assign pinRaw[PIN_FB_TIMER] = fbTimerFault;
  assign pinRaw[PIN_SAFE_DET] = safetyDetectFail;
  assign pinRaw[PIN_FB_DET] = feedbackDetectFail;
  assign pinRaw[PIN_SAFE_UNSUP] = safetyUnsupported;
  assign pinRaw[PIN_SAFE_TIMING] = safetyTimingFault;
  assign pinRaw[PIN_GATE_ONE] = gateFaultOne;
  assign pinRaw[PIN_GATE_TWO] = gateFaultTwo;

  // synchronise every pin-level fault input
  genvar g;
  generate
    for (g = 0; g < NUM_PIN; g++)
    begin : gSync
      sade_sync uSync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(pinRaw[g]),
        .syncOut(pinSync[g])
      );
    end
  endgenerate

  // magnitudes of signed deviations and position
  assign devMag = posDeviation[DEV_W-1] ? (~posDeviation + 32'h0000_0001) : posDeviation;
  assign loadMag = loadDeviation[DEV_W-1] ? (~loadDeviation + 32'h0000_0001) : loadDeviation;
  assign posMag = posFeedback[POS_W-1] ? (~posFeedback + 32'h0000_0001) : posFeedback;

  // threshold comparisons; exceeding means strictly greater
  assign devOver = devMag > {1'b0, deviation_overflow_level};
  assign devAtOnOver = devMag > {1'b0, servo_on_overflow_level};
  assign loadOver = loadMag > {1'b0, loadDeviationLevel};
  assign posOver = posMag > POS_LIMIT;

  // servo-on edge detect
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      servoOnPrev_r <= 1'b0;
    else
      servoOnPrev_r <= servoOn;
  end

  // one-cycle pulse in the cycle the servo turns on
  assign servoOnRise = servoOn && !servoOnPrev_r;

  // remember excess deviation seen while the servo is off
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      offOverflow_r <= 1'b0;
    else if (!servoOn)
      offOverflow_r <= devAtOnOver;
    else
      offOverflow_r <= 1'b0;
  end

  // servo-on speed limit: set on turn-on with remaining deviation, held until cleared
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      limit_r <= 1'b0;
    else if (!servoOn)
      limit_r <= 1'b0;
    else if (servoOnRise && (devMag != 32'h0000_0000))
      limit_r <= 1'b1;
    else if (speedLimitClear)
      limit_r <= 1'b0;
  end

  // note reference pulses arriving during the limit
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      limitPulse_r <= 1'b0;
    else if (!limit_r)
      limitPulse_r <= 1'b0;
    else if (refPulse)
      limitPulse_r <= 1'b1;
  end

  // limit value follows the motor type setting
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      speedLimitValue <= '0;
    else
      speedLimitValue <= linearMotor ? servo_on_speed_limit_lin : servo_on_speed_limit_rot;
  end
  assign speedLimitActive = limit_r;

  // per-source detection terms; lower index wins on a tie
  always_comb
  begin
    detect = '0;
    detect[SRC_FB_TIMER] = pinSync[PIN_FB_TIMER];
    detect[SRC_DEV_ON] = servoOn && !limit_r && devOver;
    detect[SRC_DEV_AT_ON] = servoOnRise && offOverflow_r;
    detect[SRC_DEV_SPDLIM] = limit_r && (limitPulse_r || refPulse) && devOver;
    detect[SRC_DEV_LOAD] = fullyClosed && loadOver;
    detect[SRC_POS_OVF] = posOver;
    // pin faults arrive two cycles late through the synchronisers
    detect[SRC_SAFE_DET] = pinSync[PIN_SAFE_DET];
    detect[SRC_FB_DET] = pinSync[PIN_FB_DET];
    detect[SRC_SAFE_UNSUP] = pinSync[PIN_SAFE_UNSUP];
    detect[SRC_SAFE_TIMING] = pinSync[PIN_SAFE_TIMING];
    detect[SRC_GATE_ONE] = pinSync[PIN_GATE_ONE];
    detect[SRC_GATE_TWO] = pinSync[PIN_GATE_TWO];
  end
  assign anyDetect = |detect;

  // encode the winning source into code, group and reset permission
  always_comb
  begin
    src_nxt = '0;
    code_nxt = CODE_NONE;
    grp_nxt = GRP_NONE;
    canReset_nxt = 1'b0;
    // scan from the top so the lowest index is left standing
    for (int i = NUM_SRC; i >= 0; i--)
    begin
      if (detect[i])
      begin
        src_nxt = SRC_W'(i);
      end
    end
    unique case (src_nxt)
      SRC_W'(SRC_FB_TIMER):
      begin
        code_nxt = CODE_COMM;
        grp_nxt = GRP_ONE;
      end
      SRC_W'(SRC_DEV_ON), SRC_W'(SRC_DEV_AT_ON):
      begin
        code_nxt = CODE_DEV;
        grp_nxt = GRP_ONE;
        canReset_nxt = 1'b1;
      end
      SRC_W'(SRC_DEV_SPDLIM), SRC_W'(SRC_DEV_LOAD):
      begin
        code_nxt = CODE_DEV;
        grp_nxt = GRP_TWO;
        canReset_nxt = 1'b1;
      end
      SRC_W'(SRC_POS_OVF):
      begin
        code_nxt = CODE_DEV;
        grp_nxt = GRP_ONE;
      end
      SRC_W'(SRC_SAFE_DET), SRC_W'(SRC_FB_DET), SRC_W'(SRC_SAFE_UNSUP):
      begin
        code_nxt = CODE_OPT;
        grp_nxt = GRP_ONE;
      end
      SRC_W'(SRC_SAFE_TIMING):
      begin
        code_nxt = CODE_OPT;
        grp_nxt = GRP_ONE;
      end
      SRC_W'(SRC_GATE_ONE), SRC_W'(SRC_GATE_TWO):
      begin
        code_nxt = CODE_OPT;
        grp_nxt = GRP_ONE;
      end
      // source indices above the last source cannot occur; stop hard if they ever do
      default:
      begin
        code_nxt = CODE_OPT;
        grp_nxt = GRP_ONE;
      end
    endcase
  end

  // first-alarm latch; reset honoured only for resettable alarms
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_CLEAR;
      src_r <= '0;
      code_r <= CODE_NONE;
      grp_r <= GRP_NONE;
      canReset_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_CLEAR:
          if (anyDetect)
          begin
            state_r <= ST_LATCHED;
            src_r <= src_nxt;
            code_r <= code_nxt;
            grp_r <= grp_nxt;
            canReset_r <= canReset_nxt;
          end
        ST_LATCHED:
          if (alarmReset && canReset_r)
          begin
            state_r <= ST_CLEAR;
            src_r <= '0;
            code_r <= CODE_NONE;
            grp_r <= GRP_NONE;
            canReset_r <= 1'b0;
          end
      endcase
    end
  end

  // outputs straight from the latch
  assign alarmActive = (state_r == ST_LATCHED);
  assign alarmSource = src_r;
  assign alarmResettable = canReset_r;
  assign stop_group_one = (grp_r == GRP_ONE);
  assign stop_group_two = (grp_r == GRP_TWO);
  assign alarm_code_line_one = code_r[2];
  assign alarm_code_line_two = code_r[1];
  assign alarm_code_line_three = code_r[0];
endmodule
`default_nettype wire

/* File: design/sade_pkg.sv */
// constants, alarm identifiers and code patterns for the alarm detect/encode block
package sade_pkg;
  // data widths
  localparam int DEV_W = 32;
  localparam int POS_W = 32;
  localparam int LVL_W = 31;
  localparam int SPD_W = 16;
  // permitted magnitude of the position feedback value
  localparam logic [POS_W-1:0] POS_LIMIT = 32'h7000_0000;
  // alarm identifiers (binary source index, 0 to 11)
  localparam int NUM_SRC = 11;
  localparam int SRC_FB_TIMER = 0;
  localparam int SRC_DEV_ON = 1;
  localparam int SRC_DEV_AT_ON = 2;
  localparam int SRC_DEV_SPDLIM = 3;
  localparam int SRC_DEV_LOAD = 4;
  localparam int SRC_POS_OVF = 5;
  localparam int SRC_SAFE_DET = 6;
  localparam int SRC_FB_DET = 7;
  localparam int SRC_SAFE_UNSUP = 8;
  localparam int SRC_SAFE_TIMING = 9;
  localparam int SRC_GATE_ONE = 10;
  localparam int SRC_GATE_TWO = 11;
  localparam int SRC_W = 4;
  // bit positions of the synchronised pin-level fault inputs
  localparam int PIN_FB_TIMER = 0;
  localparam int PIN_SAFE_DET = 1;
  localparam int PIN_FB_DET = 2;
  localparam int PIN_SAFE_UNSUP = 3;
  localparam int PIN_SAFE_TIMING = 4;
  localparam int PIN_GATE_ONE = 5;
  localparam int PIN_GATE_TWO = 6;
  // alarm code patterns, bit 2 = line one, bit 0 = line three
  localparam logic [2:0] CODE_NONE = 3'h7;
  localparam logic [2:0] CODE_COMM = 3'h2;
  localparam logic [2:0] CODE_DEV = 3'h1;
  localparam logic [2:0] CODE_OPT = 3'h4;
  // stopping groups
  typedef enum logic [1:0] {GRP_NONE, GRP_ONE, GRP_TWO} sade_grp_t;
  typedef enum logic {ST_CLEAR, ST_LATCHED} sade_state_t;
endpackage

/* File: design/sade_sync.sv */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module sade_sync
  import sade_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // level in and out
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_r;

  // first stage is read only by the second
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/sade_alarm_props.sv */
// assertions on the ports of the alarm detect/encode block
`timescale 1ns/1ps
`default_nettype none
module sade_alarm_props
  import sade_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // causes
  input wire logic servoOn,
  input wire logic [DEV_W-1:0] posDeviation,
  input wire logic [POS_W-1:0] posFeedback,
  input wire logic [LVL_W-1:0] deviation_overflow_level,
  input wire logic speedLimitClear,
  input wire logic gateFaultOne,
  input wire logic alarmReset,
  // outputs
  input wire logic alarm_code_line_one,
  input wire logic alarm_code_line_two,
  input wire logic alarm_code_line_three,
  input wire logic alarmActive,
  input wire logic stop_group_one,
  input wire logic stop_group_two,
  input wire logic alarmResettable,
  input wire logic [SRC_W-1:0] alarmSource,
  input wire logic speedLimitActive
);
  logic [2:0] code;
  logic [31:0] devMag;
  logic [31:0] posMag;
  // packed code and magnitudes of signed inputs
  assign code = {alarm_code_line_one, alarm_code_line_two, alarm_code_line_three};
  assign devMag = posDeviation[31] ? -posDeviation : posDeviation;
  assign posMag = posFeedback[31] ? -posFeedback : posFeedback;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  idle_code_a: assert property (!alarmActive |-> code == CODE_NONE)
    else $error("code lines not idle");
  code_map_a: assert property (alarmActive |->
    code == ((alarmSource == 4'h0) ? CODE_COMM : (alarmSource < 4'h6) ? CODE_DEV : CODE_OPT))
    else $error("wrong alarm code");
  group_map_a: assert property (alarmActive |->
    stop_group_two == (alarmSource inside {4'h3, 4'h4}) && stop_group_one == !stop_group_two)
    else $error("wrong stop group");
  reset_kind_a: assert property (alarmActive |->
    alarmResettable == (alarmSource inside {[4'h1:4'h4]})) else $error("wrong resettable flag");
  latch_hold_a: assert property (alarmActive && !(alarmReset && alarmResettable)
    |=> alarmActive && $stable(alarmSource) && $stable(code)) else $error("latched alarm lost");
  reset_clear_a: assert property (alarmActive && alarmResettable && alarmReset
    |=> !alarmActive) else $error("reset not taken");
  dev_trip_a: assert property (servoOn && $past(servoOn) && !speedLimitActive
    && !alarmActive && devMag > {1'b0, deviation_overflow_level} |=> alarmActive)
    else $error("deviation alarm missed");
  pos_trip_a: assert property (!alarmActive && posMag > POS_LIMIT |=> alarmActive)
    else $error("position overflow missed");
  gate_trip_a: assert property (gateFaultOne && !alarmActive |-> ##[1:4] alarmActive)
    else $error("gate fault missed");
  limit_set_a: assert property ($rose(servoOn) && posDeviation != 32'h0000_0000
    && !speedLimitClear |=> speedLimitActive) else $error("speed limit not set");
  // main scenarios reached
  cover property (alarmActive && stop_group_two);
  cover property (alarmActive && !alarmResettable);
  cover property (speedLimitActive);
endmodule
`default_nettype wire

/* File: testbench/sade_host_model.sv */
// host controller model that reads the three alarm code lines
`timescale 1ns/1ps
`default_nettype none
module sade_host_model
  import sade_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // alarm code lines from the block
  input wire logic lineOne,
  input wire logic lineTwo,
  input wire logic lineThree,
  // last code read, line one in bit 2
  output logic [2:0] seenCode
);
  // sample the lines once a cycle
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      seenCode <= CODE_NONE;
    else
      seenCode <= {lineOne, lineTwo, lineThree};
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the alarm detect/encode block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sade_pkg::*;
;
  localparam logic [30:0] DLVL = 31'h100;
  localparam logic [30:0] OLVL = 31'h80;
  localparam logic [30:0] LLVL = 31'h40;
  localparam logic [15:0] SROT = 16'h0123;
  localparam logic [15:0] SLIN = 16'h0456;
  logic core_clk, reset_n, servoOn, fullyClosed, refPulse, linearMotor, spdClr, alarmReset;
  logic [31:0] posDev, loadDev, posFb;
  logic [6:0] pins;
  wire one, two, three, active, g1, g2, rst, spdAct;
  wire [3:0] src;
  wire [15:0] spdVal;
  wire [2:0] hostCode;
  wire [11:0] st = {active, g1, g2, rst, src, 1'b0, hostCode};
  int errors = 0;
  int comparisons = 0;
  // block and host model
  sade_alarm uut (.core_clk, .reset_n, .servoOn, .fullyClosed, .refPulse, .posDeviation(posDev),
    .loadDeviation(loadDev), .posFeedback(posFb), .deviation_overflow_level(DLVL),
    .servo_on_overflow_level(OLVL), .loadDeviationLevel(LLVL), .servo_on_speed_limit_rot(SROT),
    .servo_on_speed_limit_lin(SLIN), .linearMotor, .speedLimitClear(spdClr),
    .fbTimerFault(pins[0]), .safetyDetectFail(pins[1]), .feedbackDetectFail(pins[2]),
    .safetyUnsupported(pins[3]), .safetyTimingFault(pins[4]), .gateFaultOne(pins[5]),
    .gateFaultTwo(pins[6]), .alarmReset, .alarm_code_line_one(one), .alarm_code_line_two(two),
    .alarm_code_line_three(three), .alarmActive(active), .stop_group_one(g1),
    .stop_group_two(g2), .alarmResettable(rst), .alarmSource(src),
    .speedLimitActive(spdAct), .speedLimitValue(spdVal));
  sade_host_model host (.core_clk, .reset_n, .lineOne(one), .lineTwo(two), .lineThree(three),
    .seenCode(hostCode));
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(logic [19:0] seen, logic [19:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] mk(logic [2:0] c, logic [3:0] s, logic grp2, logic r);
    return {1'b1, !grp2, grp2, r, s, 1'b0, c};
  endfunction
  task automatic idle();
    {servoOn, fullyClosed, refPulse, linearMotor, spdClr, alarmReset} = 6'h00;
    {posDev, loadDev, posFb} = 96'h0;
    pins = 7'h00;
  endtask
  task automatic hw_reset();
    reset_n = 1'b0;
    idle();
    tick(2);
    reset_n = 1'b1;
    tick();
  endtask
  task automatic settle();
    for (int i = 0; i < 10 && active !== 1'b1; i++) tick();
    tick();
  endtask
  task automatic press();
    alarmReset = 1'b1;
    tick();
    alarmReset = 1'b0;
    tick(2);
  endtask
  task automatic t_dev_on();
    servoOn = 1'b1;
    tick();
    posDev = {1'b0, DLVL};
    tick(3);
    chk({spdAct, st}, 13'h0007);
    posDev = 32'hFFFF_FEFF;
    settle();
    chk(st, mk(CODE_DEV, 4'h1, 1'b0, 1'b1));
    fullyClosed = 1'b1;
    loadDev = 32'h0000_0100;
    tick(3);
    chk(st, mk(CODE_DEV, 4'h1, 1'b0, 1'b1));
    idle();
    press();
    chk(st, 12'h007);
  endtask
  task automatic t_at_on();
    posDev = {1'b0, OLVL} + 32'h1;
    tick();
    servoOn = 1'b1;
    settle();
    chk(st, mk(CODE_DEV, 4'h2, 1'b0, 1'b1));
    hw_reset();
  endtask
  task automatic t_spdlim();
    posDev = 32'h0000_0005;
    servoOn = 1'b1;
    tick(2);
    chk({spdAct, spdVal}, {1'b1, SROT});
    linearMotor = 1'b1;
    tick(2);
    chk({spdAct, spdVal}, {1'b1, SLIN});
    refPulse = 1'b1;
    tick();
    refPulse = 1'b0;
    posDev = {1'b0, DLVL} + 32'h1;
    settle();
    chk(st, mk(CODE_DEV, 4'h3, 1'b1, 1'b1));
    spdClr = 1'b1;
    tick();
    chk({spdAct, st}, {1'b0, mk(CODE_DEV, 4'h3, 1'b1, 1'b1)});
    idle();
    press();
    chk({spdAct, st}, 13'h0007);
    hw_reset();
  endtask
  task automatic t_load();
    fullyClosed = 1'b1;
    loadDev = {1'b0, LLVL} + 32'h1;
    settle();
    chk(st, mk(CODE_DEV, 4'h4, 1'b1, 1'b1));
    hw_reset();
  endtask
  task automatic t_pos();
    posFb = POS_LIMIT;
    tick(3);
    chk(st, 12'h007);
    posFb = 32'h8FFF_FFFF;
    settle();
    chk(st, mk(CODE_DEV, 4'h5, 1'b0, 1'b0));
    posFb = 32'h0;
    press();
    chk(st, mk(CODE_DEV, 4'h5, 1'b0, 1'b0));
    hw_reset();
  endtask
  task automatic t_pins();
    for (int i = 0; i < 7; i++)
    begin
      pins = 7'h01 << i;
      settle();
      chk(st, mk(i == 0 ? CODE_COMM : CODE_OPT, 4'(i == 0 ? 0 : 5 + i), 1'b0, 1'b0));
      pins = 7'h00;
      press();
      chk(st, mk(i == 0 ? CODE_COMM : CODE_OPT, 4'(i == 0 ? 0 : 5 + i), 1'b0, 1'b0));
      hw_reset();
    end
  endtask
  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #50000;
    errors++;
    close_out();
  end
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    idle();
    tick(12);
    reset_n = 1'b1;
    tick();
    chk(st, 12'h007);
    t_dev_on();
    t_at_on();
    t_spdlim();
    t_load();
    t_pos();
    t_pins();
    close_out();
  end
endmodule
bind sade_alarm sade_alarm_props chk (.core_clk(core_clk), .reset_n(reset_n), .servoOn(servoOn),
  .posDeviation(posDeviation), .posFeedback(posFeedback),
  .deviation_overflow_level(deviation_overflow_level), .speedLimitClear(speedLimitClear),
  .gateFaultOne(gateFaultOne), .alarmReset(alarmReset),
  .alarm_code_line_one(alarm_code_line_one), .alarm_code_line_two(alarm_code_line_two),
  .alarm_code_line_three(alarm_code_line_three), .alarmActive(alarmActive),
  .stop_group_one(stop_group_one), .stop_group_two(stop_group_two),
  .alarmResettable(alarmResettable), .alarmSource(alarmSource),
  .speedLimitActive(speedLimitActive));
`default_nettype wire
